// [src/ccs_pkg.sv]
package ccs_pkg;

  // ----------------------------------------------------------------
  // bus layout
  // ----------------------------------------------------------------
  localparam int CCS_AW = 12;
  localparam int CCS_DW = 32;
  localparam logic [7:0] CCS_SEL_IDX = 8'hA9;
  localparam logic [7:0] CCS_OSC_IDX = 8'hAA;
  localparam logic [11:0] CCS_SEL_ADDR = {2'h0, CCS_SEL_IDX, 2'h0};
  localparam logic [11:0] CCS_OSC_ADDR = {2'h0, CCS_OSC_IDX, 2'h0};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CCS_SYS_LSB = 0;
  localparam int CCS_USB_LSB = 4;
  localparam int CCS_INT_EN_BIT = 0;
  localparam int CCS_MODE_LSB = 4;
  localparam int CCS_XVALID_BIT = 7;
  localparam int CCS_MULTIPLIER_INPUT_FIELD_LSB = 8;
  localparam int CCS_ACT_SYS_LSB = 12;
  localparam int CCS_ACT_USB_LSB = 16;
  localparam int CCS_ACT_MUL_LSB = 20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CCS_SYS_RST = 2'h0;
  localparam logic [2:0] CCS_USB_RST = 3'h0;
  localparam logic CCS_INT_EN_RST = 1'b1;
  localparam logic [2:0] CCS_MODE_RST = 3'h0;
  localparam logic [1:0] CCS_MULTIPLIER_INPUT_FIELD_RST = 2'h0;

  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CCS_SYS_INT = 2'h0;
  localparam logic [1:0] CCS_SYS_EXT = 2'h1;
  localparam logic [1:0] CCS_SYS_MULT = 2'h2;
  localparam logic [2:0] CCS_USB_MULT = 3'h0;
  localparam logic [2:0] CCS_USB_INT_D2 = 3'h1;
  localparam logic [2:0] CCS_USB_EXT = 3'h2;
  localparam logic [2:0] CCS_USB_EXT_D2 = 3'h3;
  localparam logic [2:0] CCS_USB_EXT_D3 = 3'h4;
  localparam logic [2:0] CCS_USB_EXT_D4 = 3'h5;
  localparam logic [1:0] CCS_MUL_INT = 2'h0;
  localparam logic [1:0] CCS_MUL_EXT = 2'h1;
  localparam logic [1:0] CCS_MUL_EXT_D2 = 2'h2;
  localparam logic [1:0] CCS_XTAL_MODE = 2'h3;

  typedef struct packed {
    logic int_osc_div;
    logic int_osc_raw;
    logic ext_osc;
    logic mult_out;
  } ccs_src_type;

  typedef enum logic {CCS_RUN, CCS_PARK} ccs_mux_state_type;

endpackage

// [src/ccs_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_clk_div
  import ccs_pkg::*;
#(
  parameter int DIV = 2,
  parameter int CW = 2
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic src_i,
  output logic clk_o
);

  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HIGH = CW'((DIV + 1) / 2);

  logic prev_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;

  // ----------------------------------------------------------------
  // count source rising edges
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (src_i && !prev_r)
    begin
      cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    end
    out_nxt = (cnt_nxt < HIGH);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_r <= 1'b0;
      cnt_r <= '0;
      out_r <= 1'b0;
    end
    else
    begin
      prev_r <= src_i;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_o = out_r;

endmodule // ccs_clk_div
`default_nettype wire

// [src/ccs_glitch_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_glitch_mux
  import ccs_pkg::*;
#(
  parameter int N = 3,
  parameter int SW = 2
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] src_i,
  input wire logic [SW-1:0] sel_i,
  output logic clk_o,
  output logic [SW-1:0] cur_o
);

  localparam logic [SW-1:0] LAST = SW'(N - 1);

  ccs_mux_state_type state_r;
  ccs_mux_state_type state_nxt;
  logic [SW-1:0] cur_r;
  logic [SW-1:0] cur_nxt;
  logic out_r;
  logic out_nxt;
  logic want;

  // ----------------------------------------------------------------
  // park while the old source is low, take the new one only while it is low
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    out_nxt = 1'b0;
    // reserved codes leave the current source running
    want = (sel_i != cur_r) && (sel_i <= LAST);
    case (state_r)
      CCS_RUN:
      begin
        out_nxt = src_i[cur_r];
        if (want && !src_i[cur_r])
        begin
          state_nxt = CCS_PARK;
          out_nxt = 1'b0;
        end
      end
      CCS_PARK:
      begin
        if (!want)
        begin
          // resume the old source only while it is low, so no runt high
          if (!src_i[cur_r])
          begin
            state_nxt = CCS_RUN;
          end
        end
        else if (!src_i[sel_i])
        begin
          cur_nxt = sel_i;
          state_nxt = CCS_RUN;
        end
      end
      default:
      begin
        state_nxt = CCS_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= CCS_RUN;
      cur_r <= '0;
      out_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_o = out_r;
  assign cur_o = cur_r;

endmodule // ccs_glitch_mux
`default_nettype wire

// [src/ccs_clock_select.sv]
// Summary of operation
// [RULE_01] internal oscillator selectable immediately after enable, no wait imposed
// [RULE_02] hardware sets crystal valid flag once external oscillator has settled
// [RULE_03] software waits 1 ms after crystal enable before reading valid flag
// [RULE_04] system source: 00 internal divided, 01 external, 10 multiplier/2, 11 reserved
// [RULE_05] external oscillator always forwarded to timers, counter array and USB
// [RULE_06] system source switchable at runtime; software picks only settled sources
// [RULE_07] USB source: multiplier, int/2, ext, ext/2, ext/3, ext/4; 110/111 reserved
// [RULE_08] software sets USB clock to 48 MHz full speed, 6 MHz low speed
// [RULE_09] select layout: bit7 zero, 6:4 USB, 3:2 zero, 1:0 system
// [RULE_10] full speed: multiplier fed by recovered internal or 12 MHz crystal
// [RULE_11] low speed: internal/2 or 24 MHz crystal divided by 4
// [RULE_12] multiplier input: 00 internal, 01 external, 10 external/2, 11 reserved
// [RULE_13] crystal valid flag meaningful only in crystal mode codes
// [RULE_14] clock multiplexers switch without runt pulses or glitches
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_select
  import ccs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CCS_AW-1:0] paddr_i,
  input wire logic [CCS_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [CCS_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ccs_src_type src_i,
  input wire logic ext_osc_stable_i,
  output logic sys_clk_o,
  output logic usb_clk_o,
  output logic mult_in_clk_o,
  output logic periph_ext_clk_o,
  output logic int_osc_en_o,
  output logic [2:0] ext_osc_mode_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] sys_field_r;
  logic [1:0] sys_field_nxt;
  logic [2:0] usb_field_r;
  logic [2:0] usb_field_nxt;
  logic int_en_r;
  logic int_en_nxt;
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  logic [1:0] multiplier_input_field_r;
  logic [1:0] multiplier_input_field_nxt;
  logic xvalid_r;
  logic xvalid_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [CCS_DW-1:0] prdata_r;
  logic [CCS_DW-1:0] prdata_nxt;
  logic [CCS_DW-1:0] rdata;
  logic ext_fwd_r;
  logic access;
  logic commit;
  logic hit_sel;
  logic hit_osc;
  logic ext_d2;
  logic ext_d3;
  logic ext_d4;
  logic int_d2;
  logic mult_d2;
  logic [1:0] act_sys;
  logic [2:0] act_usb;
  logic [1:0] act_mul;
  logic [2:0] sys_srcs;
  logic [5:0] usb_srcs;
  logic [2:0] mul_srcs;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign access = psel_i && penable_i;
  // the access phase ends at the edge where pready_r is seen high
  assign commit = access && pready_r;
  assign hit_sel = (paddr_i == CCS_SEL_ADDR);
  assign hit_osc = (paddr_i == CCS_OSC_ADDR);

  always_comb
  begin
    rdata = '0;
    if (hit_sel)
    begin
      rdata[CCS_SYS_LSB +: 2] = sys_field_r; // RULE_09
      rdata[CCS_USB_LSB +: 3] = usb_field_r; // RULE_09
    end
    else if (hit_osc)
    begin
      rdata[CCS_INT_EN_BIT] = int_en_r;
      rdata[CCS_MODE_LSB +: 3] = mode_r;
      rdata[CCS_XVALID_BIT] = xvalid_r;
      rdata[CCS_MULTIPLIER_INPUT_FIELD_LSB +: 2] = multiplier_input_field_r;
      rdata[CCS_ACT_SYS_LSB +: 2] = act_sys;
      rdata[CCS_ACT_USB_LSB +: 3] = act_usb;
      rdata[CCS_ACT_MUL_LSB +: 2] = act_mul;
    end
  end

  // ----------------------------------------------------------------
  // register file next state
  // ----------------------------------------------------------------
  always_comb
  begin
    sys_field_nxt = sys_field_r;
    usb_field_nxt = usb_field_r;
    int_en_nxt = int_en_r;
    mode_nxt = mode_r;
    multiplier_input_field_nxt = multiplier_input_field_r;
    pready_nxt = access && !pready_r;
    pslverr_nxt = access && !pready_r && !hit_sel && !hit_osc;
    prdata_nxt = '0;
    if (access && !pready_r && !pwrite_i)
    begin
      prdata_nxt = rdata;
    end
    if (commit && pwrite_i)
    begin
      if (hit_sel && pstrb_i[0])
      begin
        // unused bits are dropped here
        sys_field_nxt = pwdata_i[CCS_SYS_LSB +: 2]; // RULE_09 RULE_06
        usb_field_nxt = pwdata_i[CCS_USB_LSB +: 3]; // RULE_09
      end
      if (hit_osc && pstrb_i[0])
      begin
        int_en_nxt = pwdata_i[CCS_INT_EN_BIT];
        mode_nxt = pwdata_i[CCS_MODE_LSB +: 3];
      end
      if (hit_osc && pstrb_i[1])
      begin
        multiplier_input_field_nxt = pwdata_i[CCS_MULTIPLIER_INPUT_FIELD_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // crystal valid flag
  // ----------------------------------------------------------------
  always_comb
  begin
    // only crystal mode codes can report a settled crystal
    xvalid_nxt = (mode_r[2:1] == CCS_XTAL_MODE) && ext_osc_stable_i; // RULE_02 RULE_13
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sys_field_r <= CCS_SYS_RST;
      usb_field_r <= CCS_USB_RST;
      int_en_r <= CCS_INT_EN_RST;
      mode_r <= CCS_MODE_RST;
      multiplier_input_field_r <= CCS_MULTIPLIER_INPUT_FIELD_RST;
      xvalid_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      ext_fwd_r <= 1'b0;
    end
    else
    begin
      sys_field_r <= sys_field_nxt;
      usb_field_r <= usb_field_nxt;
      int_en_r <= int_en_nxt;
      mode_r <= mode_nxt;
      multiplier_input_field_r <= multiplier_input_field_nxt;
      xvalid_r <= xvalid_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      // external clock runs to peripherals whatever the system source
      ext_fwd_r <= src_i.ext_osc; // RULE_05
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  // internal oscillator usable as soon as this bit is set
  assign int_osc_en_o = int_en_r; // RULE_01
  assign ext_osc_mode_o = mode_r;
  assign periph_ext_clk_o = ext_fwd_r; // RULE_05

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  ccs_clk_div #(.DIV(2), .CW(2)) u_ext_d2 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(src_i.ext_osc),
    .clk_o(ext_d2)
  );

  ccs_clk_div #(.DIV(3), .CW(2)) u_ext_d3 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(src_i.ext_osc),
    .clk_o(ext_d3)
  );

  ccs_clk_div #(.DIV(4), .CW(2)) u_ext_d4 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(src_i.ext_osc),
    .clk_o(ext_d4)
  );

  ccs_clk_div #(.DIV(2), .CW(2)) u_int_d2 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(src_i.int_osc_raw),
    .clk_o(int_d2)
  );

  ccs_clk_div #(.DIV(2), .CW(2)) u_mult_d2 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(src_i.mult_out),
    .clk_o(mult_d2)
  );

  // ----------------------------------------------------------------
  // source vectors, index equals select code
  // ----------------------------------------------------------------
  always_comb
  begin
    sys_srcs = '0;
    sys_srcs[CCS_SYS_INT] = src_i.int_osc_div; // RULE_04
    sys_srcs[CCS_SYS_EXT] = src_i.ext_osc; // RULE_04
    sys_srcs[CCS_SYS_MULT] = mult_d2; // RULE_04
    usb_srcs = '0;
    usb_srcs[CCS_USB_MULT] = src_i.mult_out; // RULE_07
    usb_srcs[CCS_USB_INT_D2] = int_d2; // RULE_07
    usb_srcs[CCS_USB_EXT] = src_i.ext_osc; // RULE_07
    usb_srcs[CCS_USB_EXT_D2] = ext_d2; // RULE_07
    usb_srcs[CCS_USB_EXT_D3] = ext_d3; // RULE_07
    usb_srcs[CCS_USB_EXT_D4] = ext_d4; // RULE_07
    mul_srcs = '0;
    mul_srcs[CCS_MUL_INT] = src_i.int_osc_raw; // RULE_12
    mul_srcs[CCS_MUL_EXT] = src_i.ext_osc; // RULE_12
    mul_srcs[CCS_MUL_EXT_D2] = ext_d2; // RULE_12
  end

  // ----------------------------------------------------------------
  // glitch free selectors
  // ----------------------------------------------------------------
  ccs_glitch_mux #(.N(3), .SW(2)) u_sys_mux ( // RULE_14 RULE_06
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(sys_srcs),
    .sel_i(sys_field_r),
    .clk_o(sys_clk_o),
    .cur_o(act_sys)
  );

  ccs_glitch_mux #(.N(6), .SW(3)) u_usb_mux ( // RULE_14
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(usb_srcs),
    .sel_i(usb_field_r),
    .clk_o(usb_clk_o),
    .cur_o(act_usb)
  );

  ccs_glitch_mux #(.N(3), .SW(2)) u_mul_mux ( // RULE_14
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .src_i(mul_srcs),
    .sel_i(multiplier_input_field_r),
    .clk_o(mult_in_clk_o),
    .cur_o(act_mul)
  );

endmodule // ccs_clock_select
`default_nettype wire

// [bench/ccs_clock_select_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_select_monitor
  import ccs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CCS_AW-1:0] paddr_i,
  input wire logic [CCS_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [CCS_DW-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire ccs_src_type src_i,
  input wire logic sys_clk_o,
  input wire logic usb_clk_o,
  input wire logic periph_ext_clk_o,
  input wire logic [2:0] ext_osc_mode_o
);
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire rd_sel = pready_o && !pwrite_i && paddr_i == CCS_SEL_ADDR;
  wire rd_osc = pready_o && !pwrite_i && paddr_i == CCS_OSC_ADDR;
  answer_late_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
  err_alone_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == '0) else $error("read data outside answer");
  unmapped_err_a: assert property (pready_o && paddr_i != CCS_SEL_ADDR && paddr_i != CCS_OSC_ADDR |-> pslverr_o)
    else $error("unmapped access not refused");
  sel_zero_bits_a: assert property (rd_sel |-> prdata_o[31:7] == '0 && prdata_o[3:2] == 2'h0)
    else $error("unused select bits not zero");
  ext_forward_a: assert property ($past(rst_n_i) |-> periph_ext_clk_o == $past(src_i.ext_osc))
    else $error("external clock not forwarded");
  valid_mode_a: assert property (rd_osc && prdata_o[CCS_XVALID_BIT] |-> ext_osc_mode_o[2:1] == CCS_XTAL_MODE)
    else $error("crystal valid outside crystal mode");
  sys_no_runt_a: assert property ($rose(sys_clk_o) |=> sys_clk_o)
    else $error("runt pulse on system clock");
  usb_no_runt_a: assert property ($rose(usb_clk_o) |=> usb_clk_o)
    else $error("runt pulse on usb clock");
  mode_write_a: assert property (pready_o && pwrite_i && paddr_i == CCS_OSC_ADDR && pstrb_i[0]
    |=> ext_osc_mode_o == $past(pwdata_i[6:4])) else $error("mode write lost");
endmodule // ccs_clock_select_monitor
bind ccs_clock_select ccs_clock_select_monitor i_mon (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .src_i(src_i),
  .sys_clk_o(sys_clk_o), .usb_clk_o(usb_clk_o), .periph_ext_clk_o(periph_ext_clk_o),
  .ext_osc_mode_o(ext_osc_mode_o)
);
`default_nettype wire

// [bench/ccs_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_osc_model
  import ccs_pkg::*;
#(
  parameter int SETTLE = 40
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic int_osc_en_i,
  input wire logic [2:0] ext_osc_mode_i,
  output var ccs_src_type src_o,
  output var logic ext_stable_o
);
  logic [3:0] tick_r;
  logic [2:0] ph_r;
  int settle_r;
  wire ext_on = ext_osc_mode_i[2:1] != 2'h0;
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_r <= 4'h0;
      ph_r <= 3'h0;
      settle_r <= 0;
      src_o <= '0;
      ext_stable_o <= 1'b0;
    end
    else
    begin
      tick_r <= tick_r + 4'h1;
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      settle_r <= ext_on ? settle_r + 1 : 0;
      src_o.int_osc_raw <= int_osc_en_i && tick_r[1];
      src_o.int_osc_div <= int_osc_en_i && tick_r[3];
      src_o.mult_out <= tick_r[1];
      src_o.ext_osc <= ext_on && ph_r > 3'h2;
      // settles in rc mode too, so the flag must mask it
      ext_stable_o <= ext_on && settle_r >= SETTLE;
    end
  end
endmodule // ccs_osc_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ccs_pkg::*;
;
  localparam int SETTLE = 40;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [CCS_AW-1:0] paddr = '0;
  logic [CCS_DW-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [CCS_DW-1:0] prdata;
  logic pready, pslverr, stable, sys_clk, usb_clk, mul_clk, int_en, pext;
  logic [2:0] mode;
  ccs_src_type src;
  int errors = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  ccs_clock_select i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .src_i(src), .ext_osc_stable_i(stable), .sys_clk_o(sys_clk),
    .usb_clk_o(usb_clk), .mult_in_clk_o(mul_clk), .periph_ext_clk_o(pext), .int_osc_en_o(int_en),
    .ext_osc_mode_o(mode)
  );
  ccs_osc_model #(.SETTLE(SETTLE)) i_osc (
    .core_clk_i(clk), .rst_n_i(rst_n), .int_osc_en_i(int_en), .ext_osc_mode_i(mode),
    .src_o(src), .ext_stable_o(stable)
  );
  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [CCS_AW-1:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      errors++;
      complete_run();
    end
    @(posedge clk);
  endtask
  task automatic reg_wr(input logic [CCS_AW-1:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, s, q, e);
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? sys_clk : w == 1 ? usb_clk : w == 2 ? mul_clk : pext;
  endfunction
  // select, let the switch finish, then count rising edges over 144 cycles
  task automatic sel_case(input int w, input logic [CCS_AW-1:0] a, input logic [31:0] d, input int per);
    int n;
    logic prev;
    reg_wr(a, d);
    repeat (40) @(posedge clk);
    n = 0;
    @(negedge clk);
    prev = pick(w);
    repeat (144)
    begin
      @(negedge clk);
      if (pick(w) && !prev)
        n++;
      prev = pick(w);
    end
    @(posedge clk);
    check_val(w == 0 ? "sys rises" : w == 1 ? "usb rises" : w == 2 ? "mult rises" : "ext fwd rises", 144 / per, n);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, CCS_SEL_ADDR, 32'h0, 4'hF, q, e);
    check_val("select reset", 32'h0, q);
    apb(1'b0, 12'h000, 32'h0, 4'hF, q, e);
    check_val("unmapped err", 32'h1, {31'h0, e});
    sel_case(0, CCS_SEL_ADDR, 32'hFFFF_FFFF, 16);
    apb(1'b0, CCS_SEL_ADDR, 32'h0, 4'hF, q, e);
    check_val("select layout", 32'h73, q);
  endtask
  task automatic t_crystal();
    logic [31:0] q;
    logic e;
    reg_wr(CCS_OSC_ADDR, 32'h41);
    repeat (SETTLE + 8) @(posedge clk);
    apb(1'b0, CCS_OSC_ADDR, 32'h0, 4'hF, q, e);
    check_val("valid in rc mode", 32'h0, {31'h0, q[CCS_XVALID_BIT]});
    reg_wr(CCS_OSC_ADDR, 32'h61, 4'hE);
    check_val("mode lane off", 32'h4, {29'h0, mode});
    reg_wr(CCS_OSC_ADDR, 32'h61);
    repeat (SETTLE + 8) @(posedge clk);
    apb(1'b0, CCS_OSC_ADDR, 32'h0, 4'hF, q, e);
    check_val("crystal valid", 32'h1, {31'h0, q[CCS_XVALID_BIT]});
  endtask
  int up[8] = '{4, 8, 6, 12, 18, 24, 24, 24};
  int mp[4] = '{4, 6, 12, 12};
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_crystal();
    sel_case(0, CCS_SEL_ADDR, 32'h1, 6);
    sel_case(0, CCS_SEL_ADDR, 32'h2, 8);
    sel_case(0, CCS_SEL_ADDR, 32'h0, 16);
    foreach (up[i])
      sel_case(1, CCS_SEL_ADDR, 32'(i) << 4, up[i]);
    foreach (mp[i])
      sel_case(2, CCS_OSC_ADDR, 32'h61 | (32'(i) << 8), mp[i]);
    sel_case(2, CCS_OSC_ADDR, 32'h61, 4);
    sel_case(1, CCS_SEL_ADDR, 32'h00, 4);
    sel_case(1, CCS_SEL_ADDR, 32'h10, 8);
    sel_case(1, CCS_SEL_ADDR, 32'h50, 24);
    reg_wr(CCS_SEL_ADDR, 32'h1);
    reg_wr(CCS_OSC_ADDR, 32'h60);
    reg_wr(CCS_OSC_ADDR, 32'h61);
    sel_case(0, CCS_SEL_ADDR, 32'h0, 16);
    sel_case(3, CCS_SEL_ADDR, 32'h0, 6);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
